// ### pot_pin_sync.sv
// Purpose: Two-stage synchroniser with edge detection for the serial pins
// Assumes: Pins are asynchronous to CLK
// Notes: The first stage feeds only the second stage
`timescale 1ns/1ps
module pot_pin_sync
#(
    parameter int WIDTH = 3,                    // Number of pins
    parameter logic [WIDTH-1:0] INIT = '0       // Idle level at reset
)
(
    input wire logic CLK,                       // System clock
    input wire logic RESETN,                    // Asynchronous reset, active low
    input wire logic [WIDTH-1:0] PIN_IN,        // Raw pin levels
    output logic [WIDTH-1:0] LEVEL,             // Synchronised levels
    output logic [WIDTH-1:0] RISE,              // One-cycle rising-edge pulses
    output logic [WIDTH-1:0] FALL               // One-cycle falling-edge pulses
);

    logic [WIDTH-1:0] meta_reg;                 // First stage only
    logic [WIDTH-1:0] sync_reg;                 // Second stage, safe to use
    logic [WIDTH-1:0] prev_reg;                 // Delayed copy for edges

    // ************************************************************
    // Synchroniser chain
    // ************************************************************
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            meta_reg <= INIT;
            sync_reg <= INIT;
            prev_reg <= INIT;
        end
        else
        begin
            meta_reg <= PIN_IN;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign LEVEL = sync_reg;
    assign RISE = sync_reg & ~prev_reg;
    assign FALL = ~sync_reg & prev_reg;

endmodule // pot_pin_sync

// ### pot_spi_ctrl.sv
// Purpose: Serial slave control for a single 256-tap volatile potentiometer
// Assumes: Serial clock at least 4x slower than CLK; mode 0 framing
// Notes: Link pins are oversampled by CLK; tap outputs update at frame end
//
// Overview of operation
// - Sample serial input on rising clock, select low
// - Shift read data out on falling clock
// - Access bit 1 picks push-pull or open drain
// - Deselected means output released, standby
// - Select low makes the device active
// - Ignore traffic until first select falling edge
// - Eight-bit wiper sets tap, monotonic
// - Wiper resets to 80h
// - Address 0 wiper, 10h access control
// - New wiper applied at closing select edge
// - Leaving shutdown restores wiper at select edge
// - Access bit 6 low means shutdown
// - Instruction byte: opcode top three, address low
// - Writes take effect at closing select edge
`timescale 1ns/1ps
module pot_spi_ctrl
import pot_spi_pkg::*;
(
    input wire logic CLK,               // System clock, 125 MHz
    input wire logic RESETN,            // Asynchronous reset, active low
    input wire logic SCLK_PIN,          // Serial clock from master
    input wire logic CS_N_PIN,          // Chip select, active low
    input wire logic SERIAL_IN_PIN,     // Serial data from master
    output logic SERIAL_OUT_O,          // Serial data output level
    output logic SERIAL_OUT_OE,         // Serial output enable, high drives
    output logic [7:0] TAP_POSITION,    // Tap applied to the switches
    output logic HIGH_TERMINAL_ON,      // High terminal connected
    output logic WIPER_TO_LOW,          // Wiper tied toward low terminal
    output logic ACTIVE_MODE            // Device selected and active
);

    // ************************************************************
    // Pin synchronisation
    // ************************************************************
    logic [2:0] pin_level;              // sclk, cs_n, sdi after two flops
    logic [2:0] pin_rise;               // Rising edges
    logic [2:0] pin_fall;               // Falling edges

    // Chip select starts low in the chain, so a select already low at power-up
    // gives no falling edge; only a select seen high and then low arms the device
    pot_pin_sync #(.WIDTH(3), .INIT(3'b000)) u_sync
    (
        .CLK(CLK),
        .RESETN(RESETN),
        .PIN_IN({SCLK_PIN, CS_N_PIN, SERIAL_IN_PIN}),
        .LEVEL(pin_level),
        .RISE(pin_rise),
        .FALL(pin_fall)
    );

    wire cs_low = ~pin_level[1];        // Selected
    wire cs_open = pin_fall[1];         // Frame opens
    wire cs_close = pin_rise[1];        // Frame closes
    wire sclk_rise = pin_rise[2];       // Sample point
    wire sclk_fall = pin_fall[2];       // Launch point
    wire serial_in_pin = pin_level[0];            // Data bit

    // ************************************************************
    // State
    // ************************************************************
    logic armed_reg;                    // First select falling edge seen
    logic [7:0] wiper_reg;              // Wiper position register
    logic [7:0] access_reg;             // Access control register
    logic [7:0] shift_reg;              // Incoming byte
    logic [2:0] bit_cnt_reg;            // Bit within byte
    logic [1:0] byte_cnt_reg;           // Byte within frame, saturates at 3
    instr_s instr_reg;                  // Captured instruction
    logic wr_pend_reg;                  // Write waiting for frame end
    logic [4:0] wr_addr_reg;            // Pending write target
    logic [7:0] wr_data_reg;            // Pending write data
    logic [7:0] tx_reg;                 // Outgoing byte
    logic read_reg;                     // Frame holds a read instruction
    logic sout_reg;                     // Output data bit
    logic soe_reg;                      // Output enable
    tap_drive_s drive_reg;              // Applied tap state
    logic active_reg;                   // Active mode flag
    logic to_low_reg;                   // Wiper tied low, kept in its own flop

    // ************************************************************
    // Decode
    // ************************************************************
    function automatic logic [7:0] reg_value(input logic [4:0] a, input logic [7:0] w,
                                             input logic [7:0] c);
        if (a == ADDR_ACCESS)
            reg_value = c;
        else if (a == ADDR_WIPER || a == ADDR_WIPER_ALT)
            reg_value = w;
        else
            reg_value = 8'h00;
    endfunction

    wire take_bit = armed_reg & cs_low & sclk_rise;
    wire [7:0] byte_in = {shift_reg[6:0], serial_in_pin};                     // MSB first
    wire byte_done = take_bit & (bit_cnt_reg == 3'd7);
    instr_s instr_in;
    assign instr_in = byte_in;
    wire is_write = (instr_reg.op == OP_WR) | (instr_reg.op == OP_ACC_WR);
    wire [4:0] eff_addr = (instr_reg.op == OP_ACC_WR || instr_reg.op == OP_ACC_RD)
                          ? ADDR_ACCESS : instr_reg.addr;
    wire is_read_in = (instr_in.op == OP_RD) | (instr_in.op == OP_ACC_RD);
    wire [4:0] rd_addr_in = (instr_in.op == OP_ACC_RD) ? ADDR_ACCESS : instr_in.addr;
    wire wr_to_wiper = (wr_addr_reg == ADDR_WIPER) | (wr_addr_reg == ADDR_WIPER_ALT);
    wire wr_to_access = (wr_addr_reg == ADDR_ACCESS);
    wire commit = cs_close & wr_pend_reg;
    wire [7:0] wiper_next = (commit & wr_to_wiper) ? wr_data_reg : wiper_reg;
    wire [7:0] access_next = (commit & wr_to_access) ? (wr_data_reg & ACCESS_MASK)
                                                      : access_reg;
    wire od_mode = access_reg[ACC_OD_BIT];
    // Open drain only drives low; a one is left to the external pull-up
    wire [7:0] tx_shift = {tx_reg[6:0], 1'b0};

    // ************************************************************
    // Arming after reset
    // ************************************************************
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            armed_reg <= 1'b0;
        else if (cs_open)
            armed_reg <= 1'b1;
    end

    // ************************************************************
    // Receive framing
    // ************************************************************
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            shift_reg <= 8'h00;
            bit_cnt_reg <= 3'd0;
            byte_cnt_reg <= 2'd0;
            instr_reg <= '0;
            read_reg <= 1'b0;
        end
        else if (!cs_low)
        begin
            // Deselect restarts byte alignment for the next frame
            bit_cnt_reg <= 3'd0;
            byte_cnt_reg <= 2'd0;
            read_reg <= 1'b0;
        end
        else if (take_bit)
        begin
            shift_reg <= byte_in;
            bit_cnt_reg <= bit_cnt_reg + 3'd1;
            if (byte_done && byte_cnt_reg != 2'd3)
                byte_cnt_reg <= byte_cnt_reg + 2'd1;
            // Only byte slot 0 carries the instruction; later bytes never change the target
            if (byte_done && byte_cnt_reg == 2'd0)
            begin
                instr_reg <= instr_in;
                read_reg <= is_read_in;
            end
        end
    end

    // ************************************************************
    // Write capture, held until select rises
    // ************************************************************
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 5'd0;
            wr_data_reg <= 8'h00;
        end
        else if (!cs_low)
            wr_pend_reg <= 1'b0;
        else if (byte_done && byte_cnt_reg == 2'd1 && is_write)
        begin
            wr_pend_reg <= 1'b1;
            wr_addr_reg <= eff_addr;
            wr_data_reg <= byte_in;
        end
    end

    // ************************************************************
    // Register file; unknown addresses leave both untouched
    // ************************************************************
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            wiper_reg <= WIPER_RESET;
            access_reg <= ACCESS_RESET;
        end
        else
        begin
            wiper_reg <= wiper_next;
            access_reg <= access_next;
        end
    end

    // ************************************************************
    // Read return: echo then data, launched on falling clock
    // ************************************************************
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            tx_reg <= 8'h00;
        else if (take_bit && byte_done && byte_cnt_reg == 2'd1 && read_reg)
            tx_reg <= {ECHO_CODE, instr_reg.addr};                  // Third byte
        else if (take_bit && byte_done && byte_cnt_reg == 2'd2 && read_reg)
            tx_reg <= reg_value(eff_addr, wiper_reg, access_reg);   // Fourth byte
        else if (cs_low && sclk_fall && bit_cnt_reg != 3'd0)
            tx_reg <= tx_shift;
    end

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            sout_reg <= 1'b1;
            soe_reg <= 1'b0;
        end
        else if (!cs_low || !armed_reg)
        begin
            sout_reg <= 1'b1;
            soe_reg <= 1'b0;
        end
        else if (sclk_fall)
        begin
            // Launch the current MSB on each falling clock
            sout_reg <= (bit_cnt_reg == 3'd0) ? tx_reg[7] : tx_shift[7];
            soe_reg <= od_mode ? ~((bit_cnt_reg == 3'd0) ? tx_reg[7] : tx_shift[7])
                               : 1'b1;
        end
    end

    // ************************************************************
    // Tap drive, updated only at frame close
    // ************************************************************
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            drive_reg.wiper <= WIPER_RESET;
            drive_reg.run <= ACCESS_RESET[ACC_RUN_BIT];
            to_low_reg <= ~ACCESS_RESET[ACC_RUN_BIT];
        end
        else if (cs_close)
        begin
            drive_reg.wiper <= wiper_next;
            drive_reg.run <= access_next[ACC_RUN_BIT];
            to_low_reg <= ~access_next[ACC_RUN_BIT];
        end
    end

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            active_reg <= 1'b0;
        else
            active_reg <= armed_reg & cs_low;
    end

    assign SERIAL_OUT_O = sout_reg;
    assign SERIAL_OUT_OE = soe_reg;
    assign TAP_POSITION = drive_reg.wiper;
    assign HIGH_TERMINAL_ON = drive_reg.run;
    assign WIPER_TO_LOW = to_low_reg;
    assign ACTIVE_MODE = active_reg;

endmodule // pot_spi_ctrl

// ### pot_spi_host.sv
// Purpose: Host master model for the serial potentiometer link, mode 0
// Assumes: Half serial period of 10 CLK cycles, 80 ns
// Notes: Serial clock stands low outside frames
`timescale 1ns/1ps
module pot_spi_host
(
    input wire logic clk, // Bench clock, paces the link
    input wire logic sdo_line, // Resolved serial output line
    output logic sclk, // Serial clock, idle low
    output logic cs_n, // Chip select, active low
    output logic mosi // Serial data to the device
);
    localparam int HALF = 10; // CLK cycles per half serial period

    // Select starts low so the first frame carries no falling select edge
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b0;
        mosi = 1'b0;
    end

    // One frame of nb bytes; rx gathers the line at each rising serial clock
    task automatic xfer(input logic [31:0] tx, input int nb, output logic [31:0] rx);
        rx = '0;
        @(negedge clk);
        cs_n = 1'b0;
        repeat (HALF) @(negedge clk);
        for (int i = 0; i < nb * 8; i++)
        begin
            mosi = tx[31 - i];
            repeat (HALF) @(negedge clk);
            sclk = 1'b1;
            rx = {rx[30:0], sdo_line};
            repeat (HALF) @(negedge clk);
            sclk = 1'b0;
        end
        repeat (HALF) @(negedge clk);
        cs_n = 1'b1;
        mosi = ~mosi; // Released data line shows no stale value
        repeat (4 * HALF) @(negedge clk);
    endtask
endmodule // pot_spi_host

// ### pot_spi_pkg.sv
// Purpose: Shared constants and types for the serial potentiometer control block
// Assumes: One system clock; link pins sampled in that domain
// Notes: Register addresses are the 5-bit addresses carried in the instruction byte
package pot_spi_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [4:0] ADDR_WIPER = 5'h00;          // Wiper position register
    localparam logic [4:0] ADDR_WIPER_ALT = 5'h01;      // Wiper alias address
    localparam logic [4:0] ADDR_ACCESS = 5'h10;         // Access control register
    localparam logic [7:0] WIPER_RESET = 8'h80;         // Mid-scale at power-up
    localparam logic [7:0] ACCESS_RESET = 8'h40;        // Run mode, push-pull output
    localparam logic [7:0] ACCESS_MASK = 8'h42;         // Only bits 6 and 1 exist
    localparam int ACC_RUN_BIT = 6;                     // 1 = normal, 0 = shutdown
    localparam int ACC_OD_BIT = 1;                      // 1 = open-drain output

    // ************************************************************
    // Instruction byte
    // ************************************************************
    localparam logic [2:0] OP_NOP = 3'h0;               // No operation
    localparam logic [2:0] OP_ACC_RD = 3'h1;            // Access control read
    localparam logic [2:0] OP_ACC_WR = 3'h3;            // Access control write
    localparam logic [2:0] OP_RD = 3'h4;                // Addressed read
    localparam logic [2:0] OP_WR = 3'h6;                // Addressed write
    localparam logic [2:0] ECHO_CODE = 3'h7;            // Code returned before read data

    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed
    {
        logic [7:0] wiper;      // Tap position applied to the switches
        logic run;              // High terminal connected, tap active
    } tap_drive_s;

    typedef struct packed
    {
        logic [2:0] op;         // Operation code
        logic [4:0] addr;       // Register address
    } instr_s;

endpackage

// ### pot_spi_properties.sv
// Purpose: Port-level properties of the serial potentiometer control block
// Assumes: One CLK domain, RESETN asynchronous and active low
// Notes: Windows allow for the two-stage pin synchroniser plus one register
`timescale 1ns/1ps
module pot_spi_properties
(
    input wire logic CLK, // System clock
    input wire logic RESETN, // Reset, active low
    input wire logic CS_N_PIN, // Chip select
    input wire logic SERIAL_OUT_OE, // Output enable
    input wire logic [7:0] TAP_POSITION, // Applied tap
    input wire logic HIGH_TERMINAL_ON, // High terminal connected
    input wire logic WIPER_TO_LOW, // Wiper tied low
    input wire logic ACTIVE_MODE // Active flag
);
    // ********
    // Properties
    // ********
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RESETN);

    // Select held low long enough for the synchroniser to settle
    sequence sel_held;
        !CS_N_PIN [*5];
    endsequence
    // Select held high past the commit window
    sequence desel_held;
        CS_N_PIN [*6];
    endsequence

    chk_oe_only_sel: assert property (SERIAL_OUT_OE |-> !$past(CS_N_PIN, 5))
        else $error("output driven while deselected");
    chk_oe_idle_desel: assert property (desel_held |-> !SERIAL_OUT_OE)
        else $error("output still enabled in standby");
    chk_active_on_sel: assert property ($fell(CS_N_PIN) ##1 sel_held |-> ACTIVE_MODE)
        else $error("not active after select");
    chk_active_off_desel: assert property (desel_held |-> !ACTIVE_MODE)
        else $error("active while deselected");
    // A tap change is only legal just after a closing select edge
    chk_tap_at_commit: assert property
        ($changed(TAP_POSITION) |-> $past(CS_N_PIN, 2) && !$past(CS_N_PIN, 7))
        else $error("tap changed away from select rise");
    chk_tap_hold_frame: assert property (sel_held |-> $stable(TAP_POSITION))
        else $error("tap changed inside a frame");
    chk_run_at_commit: assert property
        ($changed(HIGH_TERMINAL_ON) |-> $past(CS_N_PIN, 2) && !$past(CS_N_PIN, 7))
        else $error("terminal changed away from select rise");
    chk_wiper_low_inv: assert property (WIPER_TO_LOW == !HIGH_TERMINAL_ON)
        else $error("shutdown outputs disagree");
endmodule // pot_spi_properties

bind pot_spi_ctrl pot_spi_properties i_pot_spi_properties
(
    .CLK(CLK),
    .RESETN(RESETN),
    .CS_N_PIN(CS_N_PIN),
    .SERIAL_OUT_OE(SERIAL_OUT_OE),
    .TAP_POSITION(TAP_POSITION),
    .HIGH_TERMINAL_ON(HIGH_TERMINAL_ON),
    .WIPER_TO_LOW(WIPER_TO_LOW),
    .ACTIVE_MODE(ACTIVE_MODE)
);

// ### tb.sv
// Purpose: Self-checking bench for the serial potentiometer control block
// Assumes: Released serial output is pulled high on the board
// Notes: Table rows run in order; each row builds on the previous state
`timescale 1ns/1ps
module tb
import pot_spi_pkg::*;
;
    typedef struct {logic [31:0] tx; int nb; logic [7:0] tap; logic run; logic [31:0] rd;} row_s;
    logic clk; // System clock
    logic resetn; // Reset, active low
    logic sclk, cs_n, mosi; // Link pins from the host model
    logic sdo_o, sdo_oe, high_on, to_low, active; // Design outputs
    logic [7:0] tap; // Applied tap
    logic [31:0] rx; // Bytes seen by the host
    int failures;
    int checks;
    wire sdo_line = sdo_oe ? sdo_o : 1'b1; // Pull-up level when released
    // ********
    // Ordinary cases: frame, bytes, tap, run, read-back
    // ********
    row_s rows [12] = '{
        '{32'hC000_0000, 2, 8'h00, 1'b1, 32'h0}, // low end
        '{32'hC0FF_0000, 2, 8'hFF, 1'b1, 32'h0}, // high end
        // First bit of a frame comes before any falling clock: released line reads 1
        '{32'h8000_0000, 4, 8'hFF, 1'b1, 32'h8000_E0FF}, // wiper read
        '{32'hC15A_0000, 2, 8'h5A, 1'b1, 32'h0}, // Alias address
        '{32'hC233_0000, 2, 8'h5A, 1'b1, 32'h0}, // unmapped
        '{32'hD033_0000, 2, 8'h5A, 1'b0, 32'h0}, // shutdown, open drain
        '{32'h9000_0000, 4, 8'h5A, 1'b0, 32'h8000_F002}, // read via pull-up
        '{32'h6040_0000, 2, 8'h5A, 1'b1, 32'h0}, // leave shutdown
        '{32'hC077_0000, 1, 8'h5A, 1'b1, 32'h0}, // Frame cut short
        '{32'hC011_2200, 3, 8'h11, 1'b1, 32'h0}, // Extra byte ignored
        '{32'h0000_0000, 2, 8'h11, 1'b1, 32'h0}, // No operation
        '{32'h3000_0000, 4, 8'h11, 1'b1, 32'h8000_F040} // Access read code
    };

    pot_spi_ctrl i_pot_spi_ctrl
    (
        .CLK(clk),
        .RESETN(resetn),
        .SCLK_PIN(sclk),
        .CS_N_PIN(cs_n),
        .SERIAL_IN_PIN(mosi),
        .SERIAL_OUT_O(sdo_o),
        .SERIAL_OUT_OE(sdo_oe),
        .TAP_POSITION(tap),
        .HIGH_TERMINAL_ON(high_on),
        .WIPER_TO_LOW(to_low),
        .ACTIVE_MODE(active)
    );

    pot_spi_host i_pot_spi_host
    (
        .clk(clk),
        .sdo_line(sdo_line),
        .sclk(sclk),
        .cs_n(cs_n),
        .mosi(mosi)
    );

    // Compare one result, zero-extended, with case equality
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Verdict and end of run
    task automatic results();
        if (failures == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Watchdog: a hang counts as a mismatch
    initial
    begin
        repeat (100000) @(posedge clk);
        failures++;
        results();
    end

    initial
    begin
        failures = 0;
        checks = 0;
        resetn = 1'b0;
        repeat (8) @(negedge clk);
        resetn = 1'b1;
        @(negedge clk);
        check(tap, WIPER_RESET);
        check(high_on, 1'b1);
        check(sdo_oe, 1'b0);
        check(active, 1'b0);
        // Select low since reset, no falling edge yet: the write must be ignored
        i_pot_spi_host.xfer(32'hC000_0000, 2, rx);
        check(tap, WIPER_RESET);
        foreach (rows[k])
        begin
            i_pot_spi_host.xfer(rows[k].tx, rows[k].nb, rx);
            check(tap, rows[k].tap);
            check(high_on, rows[k].run);
            if (rows[k].nb == 4)
                check(rx, rows[k].rd);
        end
        // Second reset in mid-run restores power-up values
        resetn = 1'b0;
        repeat (2) @(negedge clk);
        check(tap, WIPER_RESET);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        i_pot_spi_host.xfer(32'h9000_0000, 4, rx);
        check(rx, {16'h8000, 8'hF0, ACCESS_RESET});
        results();
    end
endmodule // tb
